/* verilog/adc_window_defs.svh */
// offsets, field positions and reset values of the result and window registers
`ifndef ADC_WINDOW_DEFS_SVH
`define ADC_WINDOW_DEFS_SVH

// register offsets in the special-function space
`define OFS_RESULT_HIGH      8'hBF
`define OFS_LOW_LIMIT_LOW    8'hC6
`define OFS_LOW_LIMIT_HIGH   8'hC7
`define OFS_HIGH_LIMIT_LOW   8'hC4
`define OFS_HIGH_LIMIT_HIGH  8'hC5
`define OFS_CONTROL          8'hE8

// converter control register fields
`define CTRL_LEFT_ALIGN_BIT  0
`define CTRL_WINDOW_FLAG_BIT 1

// reset values
`define RST_RESULT_HIGH      8'h00
`define RST_LOW_LIMIT_LOW    8'h00
`define RST_LOW_LIMIT_HIGH   8'h00
`define RST_HIGH_LIMIT_LOW   8'hFF
`define RST_HIGH_LIMIT_HIGH  8'hFF
`define RST_CONTROL          8'h00
`define RST_READ_DATA        8'h00

// full-scale code of a right-aligned result
`define FULL_SCALE_RIGHT     16'h0FFF

`endif

/* verilog/adc_window_pkg.sv */
// types shared by the result formatter and window detector
package adc_window_pkg;

    typedef logic [7:0]  reg_byte_type;
    typedef logic [15:0] limit_word_type;
    typedef logic [11:0] sample_type;

    typedef enum logic
    {
        ALIGN_RIGHT,
        ALIGN_LEFT
    } align_type;

endpackage : adc_window_pkg

/* verilog/window_compare.sv */
// window comparison of one aligned result against the two limit words
module window_compare
    import adc_window_pkg::*;
(
    // operands
    input  wire limit_word_type data_word,
    input  wire limit_word_type high_limit,
    input  wire limit_word_type low_limit,
    // verdict
    output logic                match
);

    logic inside_mode;

    always_comb
    begin
        inside_mode = (high_limit < low_limit);
        if (inside_mode)
        begin
            match = (data_word > high_limit) && (data_word < low_limit);
        end
        else
        begin
            match = (data_word < low_limit) || (data_word > high_limit);
        end
    end

endmodule : window_compare

/* verilog/adc_result_window_compare.sv */
// result high byte formatting and programmable window detector
//
// How it works
// - Left alignment shows bits 11-4, right alignment bits 11-8 sign-extended from bit 11.
// - Every finished conversion is compared with both limit words with no software action.
// - A result meeting the window condition sets the window match flag in the control register.
// - Software can read the window match flag, to poll it or to use it for interrupts.
// - Each limit word is loaded as a separate high byte register and low byte register.
// - How the two limits are ordered decides if results inside or outside set the flag.
// - The less-than word is its high byte above its low byte, each eight bits wide.
// - Right-aligned results compare as codes 0 to 0x0FFF, limits in the same alignment.
`include "adc_window_defs.svh"

module adc_result_window_compare
    import adc_window_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // special-function register port
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    // converter result
    input  wire logic       conv_done,
    input  wire sample_type conv_result,
    // window status
    output logic            window_match_flag
);

    reg_byte_type   result_high_byte;
    reg_byte_type   window_low_limit_low_byte;
    reg_byte_type   window_low_limit_high_byte;
    reg_byte_type   window_high_limit_low_byte;
    reg_byte_type   window_high_limit_high_byte;
    align_type      result_left_align;
    logic [5:0]     control_upper;
    limit_word_type window_low_limit_regs;
    limit_word_type window_high_limit_regs;
    limit_word_type compare_word;
    reg_byte_type   next_result_high;
    reg_byte_type   control_view;
    logic           window_hit;
    logic           flag_set;
    logic           wr_control;
    logic           wr_result;
    logic           wr_low_low;
    logic           wr_low_high;
    logic           wr_high_low;
    logic           wr_high_high;

    // write strobes
    assign wr_control   = sfr_wr && (sfr_addr == `OFS_CONTROL);
    assign wr_result    = sfr_wr && (sfr_addr == `OFS_RESULT_HIGH);
    assign wr_low_low   = sfr_wr && (sfr_addr == `OFS_LOW_LIMIT_LOW);
    assign wr_low_high  = sfr_wr && (sfr_addr == `OFS_LOW_LIMIT_HIGH);
    assign wr_high_low  = sfr_wr && (sfr_addr == `OFS_HIGH_LIMIT_LOW);
    assign wr_high_high = sfr_wr && (sfr_addr == `OFS_HIGH_LIMIT_HIGH);

    assign window_low_limit_regs  = {window_low_limit_high_byte, window_low_limit_low_byte};
    assign window_high_limit_regs = {window_high_limit_high_byte, window_high_limit_low_byte};

    assign compare_word = (result_left_align == ALIGN_LEFT) ? {conv_result, 4'h0}
                                                            : {4'h0, conv_result};

    assign next_result_high = (result_left_align == ALIGN_LEFT) ? conv_result[11:4]
                            : {{4{conv_result[11]}}, conv_result[11:8]};

    window_compare u_window_compare
    (
        .data_word  (compare_word),
        .high_limit (window_high_limit_regs),
        .low_limit  (window_low_limit_regs),
        .match      (window_hit)
    );

    assign flag_set = conv_done && window_hit;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            window_low_limit_low_byte   <= `RST_LOW_LIMIT_LOW;
            window_low_limit_high_byte  <= `RST_LOW_LIMIT_HIGH;
            window_high_limit_low_byte  <= `RST_HIGH_LIMIT_LOW;
            window_high_limit_high_byte <= `RST_HIGH_LIMIT_HIGH;
        end
        else
        begin
            if (wr_low_low)
                window_low_limit_low_byte <= sfr_wdata;
            if (wr_low_high)
                window_low_limit_high_byte <= sfr_wdata;
            if (wr_high_low)
                window_high_limit_low_byte <= sfr_wdata;
            if (wr_high_high)
                window_high_limit_high_byte <= sfr_wdata;
        end
    end

    // control bits other than the flag
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            result_left_align <= ALIGN_RIGHT;
            control_upper     <= 6'(`RST_CONTROL >> 2);
        end
        else if (wr_control)
        begin
            result_left_align <= align_type'(sfr_wdata[`CTRL_LEFT_ALIGN_BIT]);
            control_upper     <= sfr_wdata[7:2];
        end
    end

    // result high byte, conversion beats a write
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            result_high_byte <= `RST_RESULT_HIGH;
        else if (conv_done)
            result_high_byte <= next_result_high;
        else if (wr_result)
            result_high_byte <= sfr_wdata;
    end

    // sticky flag, set wins over clear
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            window_match_flag <= 1'b0;
        else if (flag_set)
            window_match_flag <= 1'b1;
        else if (wr_control)
            window_match_flag <= sfr_wdata[`CTRL_WINDOW_FLAG_BIT];
    end

    assign control_view = {control_upper, window_match_flag, result_left_align};

    // registered read data, unmapped reads return zero
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            sfr_rdata <= `RST_READ_DATA;
        else if (sfr_rd)
        begin
            case (sfr_addr)
                `OFS_CONTROL:         sfr_rdata <= control_view;
                `OFS_RESULT_HIGH:     sfr_rdata <= result_high_byte;
                `OFS_LOW_LIMIT_LOW:   sfr_rdata <= window_low_limit_low_byte;
                `OFS_LOW_LIMIT_HIGH:  sfr_rdata <= window_low_limit_high_byte;
                `OFS_HIGH_LIMIT_LOW:  sfr_rdata <= window_high_limit_low_byte;
                `OFS_HIGH_LIMIT_HIGH: sfr_rdata <= window_high_limit_high_byte;
                default:              sfr_rdata <= `RST_READ_DATA;
            endcase
        end
    end

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_flag_set_match: assert property (
        flag_set |=> window_match_flag)
        else $error("window flag not set after matching conversion");

    a_flag_stays_set: assert property (
        window_match_flag && !(wr_control && !sfr_wdata[`CTRL_WINDOW_FLAG_BIT])
        |=> window_match_flag)
        else $error("window flag dropped without software clear");

    a_flag_sw_clear: assert property (
        wr_control && !sfr_wdata[`CTRL_WINDOW_FLAG_BIT] && !flag_set
        |=> !window_match_flag)
        else $error("window flag not cleared by zero write");

    a_flag_no_spurious: assert property (
        !window_match_flag && !conv_done && !wr_control |=> !window_match_flag)
        else $error("window flag set without conversion");

    a_window_inside: assert property (
        conv_done && (window_high_limit_regs < window_low_limit_regs)
        && (compare_word > window_high_limit_regs) && (compare_word < window_low_limit_regs)
        |=> window_match_flag)
        else $error("inside window result did not set flag");

    a_window_outside: assert property (
        conv_done && !window_match_flag && !wr_control
        && (window_high_limit_regs >= window_low_limit_regs)
        && (compare_word >= window_low_limit_regs) && (compare_word <= window_high_limit_regs)
        |=> !window_match_flag)
        else $error("result inside outside-mode window set flag");

    a_high_left_align: assert property (
        conv_done && (result_left_align == ALIGN_LEFT)
        |=> {4'h0, result_high_byte} == ($past(conv_result) >> 4))
        else $error("left aligned high byte wrong");

    a_high_right_sign: assert property (
        conv_done && (result_left_align == ALIGN_RIGHT)
        |=> ({8'h00, result_high_byte[3:0]} == ($past(conv_result) >> 8))
            && (result_high_byte[7:4] == {4{result_high_byte[3]}}))
        else $error("right aligned high byte wrong");

    a_full_scale_right: assert property (
        conv_done && (result_left_align == ALIGN_RIGHT)
        && ({4'h0, conv_result} == `FULL_SCALE_RIGHT)
        && (window_high_limit_regs >= window_low_limit_regs)
        && (window_high_limit_regs < `FULL_SCALE_RIGHT)
        |=> window_match_flag)
        else $error("full scale result above limit did not set flag");

    a_read_flag_bit: assert property (
        sfr_rd && (sfr_addr == `OFS_CONTROL)
        |=> sfr_rdata[`CTRL_WINDOW_FLAG_BIT] == $past(window_match_flag))
        else $error("flag not visible on control read");

    a_limit_byte_load: assert property (
        wr_high_low ##1 !wr_high_low
        ##1 (sfr_rd && (sfr_addr == `OFS_HIGH_LIMIT_LOW) && !wr_high_low)
        |=> sfr_rdata == $past(sfr_wdata, 3))
        else $error("greater-than low byte not loaded");

    a_low_word_order: assert property (
        wr_low_high |=> window_low_limit_regs[15:8] == $past(sfr_wdata))
        else $error("less-than high byte not in upper half");

    c_inside_hit: cover property (
        conv_done && window_hit && (window_high_limit_regs < window_low_limit_regs));
    c_outside_hit: cover property (
        conv_done && window_hit && (window_high_limit_regs >= window_low_limit_regs));
    c_set_beats_clear: cover property (
        flag_set && wr_control && !sfr_wdata[`CTRL_WINDOW_FLAG_BIT]);
    c_poll_flag: cover property (
        window_match_flag && sfr_rd && (sfr_addr == `OFS_CONTROL));

endmodule : adc_result_window_compare

/* test/tb_top.sv */
// self-checking bench for the result formatter and window detector
`include "adc_window_defs.svh"
module tb_top
    import adc_window_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic       clk;
    logic       rst_n;
    logic [7:0] sfr_addr;
    logic       sfr_wr;
    logic       sfr_rd;
    logic [7:0] sfr_wdata;
    logic [7:0] sfr_rdata;
    logic       conv_done;
    sample_type conv_result;
    logic       window_match_flag;
    logic [7:0] ctrl;
    int         failures;
    int         n_tests;
    localparam logic [7:0] ADDRS [7] = '{`OFS_RESULT_HIGH, `OFS_LOW_LIMIT_LOW,
        `OFS_LOW_LIMIT_HIGH, `OFS_HIGH_LIMIT_LOW, `OFS_HIGH_LIMIT_HIGH, `OFS_CONTROL, 8'h10};
    localparam logic [7:0] RSTS [7] = '{`RST_RESULT_HIGH, `RST_LOW_LIMIT_LOW,
        `RST_LOW_LIMIT_HIGH, `RST_HIGH_LIMIT_LOW, `RST_HIGH_LIMIT_HIGH, `RST_CONTROL,
        `RST_READ_DATA};
    // bit 12 is the expected flag, bits 11-0 the result
    localparam logic [12:0] IN_CASES  [6] = '{13'h1180, 13'h1101, 13'h11FF, 13'h0200,
        13'h0100, 13'h0000};
    localparam logic [12:0] OUT_CASES [7] = '{13'h10FF, 13'h1201, 13'h1FFF, 13'h1000,
        13'h0150, 13'h0100, 13'h0200};
    adc_result_window_compare adc_result_window_compare_i
    (
        .clk               (clk),
        .rst_n             (rst_n),
        .sfr_addr          (sfr_addr),
        .sfr_wr            (sfr_wr),
        .sfr_rd            (sfr_rd),
        .sfr_wdata         (sfr_wdata),
        .sfr_rdata         (sfr_rdata),
        .conv_done         (conv_done),
        .conv_result       (conv_result),
        .window_match_flag (window_match_flag)
    );
    always #2.5 clk = ~clk;
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : conclude
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 sfr_wr = 1'b1;
        sfr_addr  = a;
        sfr_wdata = d;
        @(posedge clk);
        #1 sfr_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        #1 sfr_rd = 1'b1;
        sfr_addr  = a;
        @(posedge clk);
        #1 sfr_rd = 1'b0;
        check(sfr_rdata, exp);
    endtask : rd
    task automatic set_limits(input limit_word_type gt, input limit_word_type lt);
        wr(`OFS_HIGH_LIMIT_HIGH, gt[15:8]);
        wr(`OFS_HIGH_LIMIT_LOW, gt[7:0]);
        wr(`OFS_LOW_LIMIT_HIGH, lt[15:8]);
        wr(`OFS_LOW_LIMIT_LOW, lt[7:0]);
    endtask : set_limits
    task automatic pulse(input sample_type res);
        @(posedge clk);
        #1 conv_done = 1'b1;
        conv_result  = res;
        @(posedge clk);
        #1 conv_done = 1'b0;
    endtask : pulse
    task automatic conv_chk(input sample_type res, input logic exp_flag);
        logic [7:0] hb;
        hb = ctrl[0] ? res[11:4] : {{4{res[11]}}, res[11:8]};
        pulse(res);
        check({7'h00, window_match_flag}, {7'h00, exp_flag});
        rd(`OFS_RESULT_HIGH, hb);
        rd(`OFS_CONTROL, ctrl | {6'h00, exp_flag, 1'b0});
        wr(`OFS_CONTROL, ctrl);
        check({7'h00, window_match_flag}, 8'h00);
    endtask : conv_chk
    initial
    begin
        clk = 0;
        rst_n = 0;
        sfr_addr = 8'h00;
        sfr_wr = 0;
        sfr_rd = 0;
        sfr_wdata = 8'h00;
        conv_done = 0;
        conv_result = 12'h000;
        ctrl = 8'h00;
        failures = 0;
        n_tests = 0;
        repeat (20) @(posedge clk);
        #1 rst_n = 1;
        check({7'h00, window_match_flag}, 8'h00);
        for (int i = 0; i < 7; i++)
            rd(ADDRS[i], RSTS[i]);
        $display("reset values done");
        for (int i = 0; i < 5; i++)
            wr(ADDRS[i], ADDRS[i] ^ 8'h5A);
        wr(8'h10, 8'hFF);
        for (int i = 0; i < 7; i++)
            rd(ADDRS[i], i < 5 ? ADDRS[i] ^ 8'h5A : 8'h00);
        wr(`OFS_CONTROL, 8'hFC);
        rd(`OFS_CONTROL, 8'hFC);
        wr(`OFS_CONTROL, 8'h00);
        wr(`OFS_HIGH_LIMIT_LOW, 8'hA7);
        rd(`OFS_HIGH_LIMIT_LOW, 8'hA7);
        $display("register access done");
        set_limits(16'h0100, 16'h0200);
        foreach (IN_CASES[i])
            conv_chk(IN_CASES[i][11:0], IN_CASES[i][12]);
        $display("inside window done");
        set_limits(16'h0200, 16'h0100);
        foreach (OUT_CASES[i])
            conv_chk(OUT_CASES[i][11:0], OUT_CASES[i][12]);
        set_limits(16'h0180, 16'h0180);
        conv_chk(12'h180, 1'b0);
        conv_chk(12'h17F, 1'b1);
        $display("outside window done");
        pulse(12'h000);
        pulse(12'h180);
        check({7'h00, window_match_flag}, 8'h01);
        wr(`OFS_CONTROL, 8'h00);
        check({7'h00, window_match_flag}, 8'h00);
        wr(`OFS_CONTROL, 8'h02);
        check({7'h00, window_match_flag}, 8'h01);
        wr(`OFS_CONTROL, 8'h00);
        check({7'h00, window_match_flag}, 8'h00);
        $display("sticky flag done");
        ctrl = 8'h01;
        wr(`OFS_CONTROL, ctrl);
        set_limits(16'h0100, 16'h0200);
        conv_chk(12'h018, 1'b1);
        conv_chk(12'h020, 1'b0);
        conv_chk(12'hA5C, 1'b0);
        $display("left alignment done");
        conclude();
    end
    initial
    begin
        #400000;
        failures++;
        conclude();
    end
endmodule : tb_top
